// file: design/sstx_defines.svh
// Constants for the subtract, swap and direction-load execute slice.
`ifndef SSTX_DEFINES_SVH
`define SSTX_DEFINES_SVH

`define SSTX_OP_SUB_TOP    6'h02
`define SSTX_OP_SWAP_TOP   6'h0E
`define SSTX_OP_LDIR_TOP   11'h00C
`define SSTX_OP_TOP_LSB    8
`define SSTX_OP_LDIR_LSB   3
`define SSTX_DEST_BIT      7
`define SSTX_DIR_SEL_MIN   3'h5
`define SSTX_DIR_SEL_MAX   3'h7
`define SSTX_DIR_ADDR_BASE 7'h05
`define SSTX_DIR_ADDR_LAST 7'h07
`define SSTX_DIR_RESET     8'hFF
`define SSTX_ACC_RESET     8'h00
`define SSTX_FLAG_RESET    1'b0
`define SSTX_EXEC_CYCLES   1

`endif

// file: design/sstx_pkg.sv
// Types shared by the execute slice.
package sstx_pkg;
    typedef struct packed {
        logic       carry;
        logic       half_borrow_flag;
        logic       zero;
    } sstx_flags_t;

    typedef struct packed {
        logic       we;
        logic [6:0] addr;
        logic [7:0] data;
    } sstx_fwrite_t;
endpackage

// file: design/sstx_exec.sv
// Execute slice for subtract, nibble swap and direction-load instructions.
`timescale 1ns/1ps
`include "sstx_defines.svh"

module sstx_exec #(
    parameter int DATA_W = 8,
    parameter int ADDR_W = 7,
    parameter int OP_W   = 14
) (
    input  wire logic                  i_clock,
    input  wire logic                  i_rstn,
    input  wire logic                  i_valid,
    input  wire logic [OP_W-1:0]       i_opcode,
    input  wire logic [DATA_W-1:0]     i_file_rdata,
    output logic [ADDR_W-1:0]          o_file_raddr,
    output sstx_pkg::sstx_fwrite_t     o_file_write,
    output logic [DATA_W-1:0]          o_acc,
    output sstx_pkg::sstx_flags_t      o_flags,
    output logic [DATA_W-1:0]          o_dir5,
    output logic [DATA_W-1:0]          o_dir6,
    output logic [DATA_W-1:0]          o_dir7,
    output logic                       o_done
);

    ////////////////////////////////////////////////////////////////////////////
    // Elaboration check.

    // The nibble swap, the opcode fields and the packed write record are fixed to these widths.
    if (DATA_W != 8 || ADDR_W != 7 || OP_W != 14) begin : g_width_check
        $error("sstx_exec serves only DATA_W 8, ADDR_W 7 and OP_W 14.");
    end

    ////////////////////////////////////////////////////////////////////////////
    // Declarations.

    localparam int TOP_W  = OP_W - `SSTX_OP_TOP_LSB;
    localparam int LDIR_W = OP_W - `SSTX_OP_LDIR_LSB;
    localparam int NIB_W  = DATA_W / 2;

    logic [TOP_W-1:0]       op_top;
    logic [LDIR_W-1:0]      op_ldir;
    logic [ADDR_W-1:0]      faddr;
    logic                   dest;
    logic [2:0]             dsel;
    logic                   sel_ok;
    logic                   is_sub;
    logic                   is_swap;
    logic                   is_ldir;
    logic                   dir_target;

    logic [DATA_W-1:0]      acc_q;
    logic                   carry_q;
    logic                   half_borrow_q;
    logic                   zero_q;
    sstx_pkg::sstx_fwrite_t fwrite_q;
    logic                   done_q;
    logic [DATA_W-1:0]      dir_q [0:2];

    logic [DATA_W-1:0]      operand;
    logic [DATA_W:0]        diff;
    logic [NIB_W:0]         ndiff;
    logic [DATA_W-1:0]      result;
    logic                   acc_we;
    logic                   file_we;
    logic                   dir_we;

    ////////////////////////////////////////////////////////////////////////////
    // Helpers.

    // True for the three direction registers that this slice holds itself.
    function automatic logic is_dir_addr(input logic [ADDR_W-1:0] addr);
        is_dir_addr = (addr >= `SSTX_DIR_ADDR_BASE) && (addr <= `SSTX_DIR_ADDR_LAST);
    endfunction

    // Selections and addresses 5, 6 and 7 map to slots 0, 1 and 2.
    function automatic logic [1:0] dir_slot(input logic [1:0] sel_low);
        dir_slot = sel_low - 2'h1;
    endfunction

    // Exchanges the upper and lower halves of a data word.
    function automatic logic [DATA_W-1:0] swap_nibbles(input logic [DATA_W-1:0] value);
        swap_nibbles = {value[NIB_W-1:0], value[DATA_W-1:NIB_W]};
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Decode.

    assign op_top     = i_opcode[OP_W-1:`SSTX_OP_TOP_LSB];
    assign op_ldir    = i_opcode[OP_W-1:`SSTX_OP_LDIR_LSB];
    assign faddr      = i_opcode[ADDR_W-1:0];
    assign dest       = i_opcode[`SSTX_DEST_BIT];
    assign dsel       = i_opcode[`SSTX_OP_LDIR_LSB-1:0];
    assign sel_ok     = (dsel >= `SSTX_DIR_SEL_MIN) && (dsel <= `SSTX_DIR_SEL_MAX);
    assign is_sub     = i_valid && (op_top == `SSTX_OP_SUB_TOP);
    assign is_swap    = i_valid && (op_top == `SSTX_OP_SWAP_TOP);
    assign is_ldir    = i_valid && (op_ldir == `SSTX_OP_LDIR_TOP) && sel_ok;
    assign dir_target = is_dir_addr(faddr);

    ////////////////////////////////////////////////////////////////////////////
    // Operand and arithmetic.

    // Direction registers live here, so reads of them come from local state, not the file bus.
    assign operand = dir_target ? dir_q[dir_slot(faddr[1:0])] : i_file_rdata;

    // The extra top bit of each difference is the borrow; carry and half borrow are its inverse.
    assign diff   = {1'b0, operand} - {1'b0, acc_q};
    assign ndiff  = {1'b0, operand[NIB_W-1:0]} - {1'b0, acc_q[NIB_W-1:0]};
    assign result = is_sub ? diff[DATA_W-1:0] : swap_nibbles(operand);

    assign acc_we  = (is_sub || is_swap) && !dest;
    assign file_we = (is_sub || is_swap) && dest && !dir_target;
    assign dir_we  = (is_sub || is_swap) && dest && dir_target;

    ////////////////////////////////////////////////////////////////////////////
    // Accumulator.

    always_ff @(posedge i_clock or negedge i_rstn) begin
        if (!i_rstn) begin
            acc_q <= `SSTX_ACC_RESET;
        end else if (acc_we) begin
            acc_q <= result;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Status flags.

    // Only the subtract touches the flags; swap and direction-load leave them alone.
    always_ff @(posedge i_clock or negedge i_rstn) begin
        if (!i_rstn) begin
            carry_q <= `SSTX_FLAG_RESET;
        end else if (is_sub) begin
            carry_q <= ~diff[DATA_W];
        end
    end

    always_ff @(posedge i_clock or negedge i_rstn) begin
        if (!i_rstn) begin
            half_borrow_q <= `SSTX_FLAG_RESET;
        end else if (is_sub) begin
            half_borrow_q <= ~ndiff[NIB_W];
        end
    end

    always_ff @(posedge i_clock or negedge i_rstn) begin
        if (!i_rstn) begin
            zero_q <= `SSTX_FLAG_RESET;
        end else if (is_sub) begin
            zero_q <= (diff[DATA_W-1:0] == '0);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // File writeback.

    // The write lands one cycle after the instruction, so a read of the same external
    // address in the very next cycle still sees the old value.
    always_ff @(posedge i_clock or negedge i_rstn) begin
        if (!i_rstn) begin
            fwrite_q <= '0;
        end else begin
            fwrite_q.we   <= file_we;
            fwrite_q.addr <= faddr;
            fwrite_q.data <= result;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Direction registers.

    // Written by direction-load or by an ordinary destination write to their address.
    always_ff @(posedge i_clock or negedge i_rstn) begin
        if (!i_rstn) begin
            dir_q[0] <= `SSTX_DIR_RESET;
            dir_q[1] <= `SSTX_DIR_RESET;
            dir_q[2] <= `SSTX_DIR_RESET;
        end else if (is_ldir) begin
            dir_q[dir_slot(dsel[1:0])] <= acc_q;
        end else if (dir_we) begin
            dir_q[dir_slot(faddr[1:0])] <= result;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Completion.

    // Every recognised instruction finishes in a single cycle, so done trails decode by one edge.
    always_ff @(posedge i_clock or negedge i_rstn) begin
        if (!i_rstn) begin
            done_q <= 1'b0;
        end else begin
            done_q <= is_sub || is_swap || is_ldir;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs.

    // The read address must reach the file in the cycle of the instruction, so it is not registered.
    assign o_file_raddr = faddr;
    assign o_file_write = fwrite_q;
    assign o_acc        = acc_q;
    assign o_flags      = {carry_q, half_borrow_q, zero_q};
    assign o_dir5       = dir_q[0];
    assign o_dir6       = dir_q[1];
    assign o_dir7       = dir_q[2];
    assign o_done       = done_q;

endmodule

// file: tb/sstx_exec_sva.sv
// Checker for the subtract, swap and direction-load slice.
`timescale 1ns/1ps
module sstx_exec_sva (
    input wire logic                   i_clock,
    input wire logic                   i_rstn,
    input wire logic                   i_valid,
    input wire logic [13:0]            i_opcode,
    input wire logic [7:0]             i_file_rdata,
    input wire logic [7:0]             o_acc,
    input wire logic [7:0]             o_dir7,
    input wire sstx_pkg::sstx_fwrite_t o_file_write,
    input wire sstx_pkg::sstx_flags_t  o_flags,
    input wire logic                   o_done
);
    default clocking @(posedge i_clock); endclocking
    default disable iff (!i_rstn);
    // Top opcode bits with destination; addresses below 8, local direction registers among them, map to a dead code.
    wire [6:0] op_key = (i_valid && |i_opcode[6:3]) ? i_opcode[13:7] : 7'h7F;
    sequence s_sub;     op_key[6:1] == 6'h02; endsequence
    sequence s_sub_acc; op_key == 7'h04; endsequence
    sequence s_sub_fil; op_key == 7'h05; endsequence
    sequence s_swp_acc; op_key == 7'h1C; endsequence
    sequence s_swp_fil; op_key == 7'h1D; endsequence
    sequence s_ldir7;   i_valid && i_opcode == 14'h0067; endsequence
    property p_sub_w;
        s_sub_acc |=> o_acc == $past(i_file_rdata) - $past(o_acc);
    endproperty
    a_sub_w: assert property (p_sub_w) else $error("sub acc");
    property p_sub_f;
        s_sub_fil |=> o_file_write.we && o_file_write.data == $past(i_file_rdata) - $past(o_acc);
    endproperty
    a_sub_f: assert property (p_sub_f) else $error("sub file");
    property p_c;
        s_sub |=> o_flags.carry == ($past(i_file_rdata) >= $past(o_acc));
    endproperty
    a_c: assert property (p_c) else $error("carry");
    property p_z;
        s_sub |=> o_flags.zero == ($past(i_file_rdata) == $past(o_acc));
    endproperty
    a_z: assert property (p_z) else $error("zero");
    property p_h;
        s_sub |=> o_flags.half_borrow_flag == ($past(i_file_rdata[3:0]) >= $past(o_acc[3:0]));
    endproperty
    a_h: assert property (p_h) else $error("half borrow");
    property p_x0;
        s_swp_acc |=> {o_acc[3:0], o_acc[7:4]} == $past(i_file_rdata) && $stable(o_flags);
    endproperty
    a_x0: assert property (p_x0) else $error("swap acc");
    property p_x1;
        s_swp_fil |=> o_file_write.we && {o_file_write.data[3:0], o_file_write.data[7:4]} == $past(i_file_rdata);
    endproperty
    a_x1: assert property (p_x1) else $error("swap file");
    property p_l;
        s_ldir7 |=> o_dir7 == $past(o_acc) && $stable(o_flags);
    endproperty
    a_l: assert property (p_l) else $error("dir load");
    property p_d;
        op_key[6:1] == 6'h02 || op_key[6:1] == 6'h0E |=> o_done;
    endproperty
    a_d: assert property (p_d) else $error("done");
endmodule
bind sstx_exec sstx_exec_sva sstx_exec_sva_inst (
    .i_clock      (i_clock),
    .i_rstn       (i_rstn),
    .i_valid      (i_valid),
    .i_opcode     (i_opcode),
    .i_file_rdata (i_file_rdata),
    .o_acc        (o_acc),
    .o_dir7       (o_dir7),
    .o_file_write (o_file_write),
    .o_flags      (o_flags),
    .o_done       (o_done)
);

// file: tb/sstx_exec_bench.sv
// Bench for the subtract, swap and direction-load slice.
`timescale 1ns/1ps
module sstx_exec_bench;
    logic                   i_clock      = 1'h0;
    logic                   i_rstn       = 1'h0;
    logic                   i_valid      = 1'h0;
    logic [13:0]            i_opcode     = 14'h0000;
    logic [7:0]             i_file_rdata = 8'h00;
    logic                   o_done;
    logic [7:0]             o_acc;
    logic [7:0]             o_dir5;
    logic [7:0]             o_dir6;
    logic [7:0]             o_dir7;
    logic [6:0]             o_file_raddr;
    sstx_pkg::sstx_fwrite_t o_file_write;
    sstx_pkg::sstx_flags_t  o_flags;
    int                     fail_count   = 0;
    int                     checks_done  = 0;
    // Rows hold opcode, file operand, expected accumulator, expected flags and expected done.
    logic [33:0]            rows [6] = '{{14'h0E20, 8'hA5, 8'h5A, 3'h0, 1'h1}, {14'h0220, 8'h10, 8'hB6, 3'h0, 1'h1},
        {14'h02A0, 8'hB6, 8'hB6, 3'h7, 1'h1}, {14'h0EA0, 8'h12, 8'hB6, 3'h7, 1'h1},
        {14'h0067, 8'h00, 8'hB6, 3'h7, 1'h1}, {14'h0064, 8'h00, 8'hB6, 3'h7, 1'h0}};
    sstx_exec sstx_exec_inst (
        .i_clock      (i_clock),
        .i_rstn       (i_rstn),
        .i_valid      (i_valid),
        .i_opcode     (i_opcode),
        .i_file_rdata (i_file_rdata),
        .o_file_raddr (o_file_raddr),
        .o_file_write (o_file_write),
        .o_acc        (o_acc),
        .o_flags      (o_flags),
        .o_dir5       (o_dir5),
        .o_dir6       (o_dir6),
        .o_dir7       (o_dir7),
        .o_done       (o_done)
    );
    task automatic chk(input logic [15:0] seen, input logic [15:0] want);
        checks_done++;
        if (seen !== want) begin
            fail_count++;
            $display("ERROR %0t got %h want %h", $time, seen, want);
        end
    endtask
    task automatic issue(input logic [13:0] op, input logic [7:0] rd);
        @(posedge i_clock) {i_valid, i_opcode, i_file_rdata} <= {1'h1, op, rd};
    endtask
    task automatic give_verdict;
        $display("%0d checks, %0d mismatches", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    initial forever #10 i_clock = ~i_clock;
    // The tests need about 32 cycles; 250 cycles means a hang.
    initial begin
        #5000;
        fail_count++;
        give_verdict();
    end
    initial begin
        repeat (8) @(posedge i_clock);
        i_rstn <= 1'h1;
        #1 chk(16'(o_acc), 16'h0000);
        chk(16'(o_flags), 16'h0000);
        chk(16'(o_dir6), 16'h00FF);
        chk(16'(o_done), 16'h0000);
        $display("reset values done");
        foreach (rows[i]) begin
            issue(rows[i][33:20], rows[i][19:12]);
            #1 chk(16'(o_file_raddr), 16'(rows[i][26:20]));
            @(posedge i_clock) i_valid <= 1'h0;
            #1 chk(16'(o_acc), 16'(rows[i][11:4]));
            chk(16'(o_flags), 16'(rows[i][3:1]));
            chk(16'(o_done), 16'(rows[i][0]));
        end
        chk(16'(o_dir5), 16'h00FF);
        chk(16'(o_dir6), 16'h00FF);
        chk(16'(o_dir7), 16'h00B6);
        $display("table done");
        issue(14'h02A1, 8'hB7);
        issue(14'h0285, 8'h00);
        #1 chk(16'(o_file_write), 16'hA101);
        chk(16'(o_done), 16'h0001);
        @(posedge i_clock) i_valid <= 1'h0;
        #1 chk(16'(o_dir5), 16'h0049);
        chk(16'(o_file_write.we), 16'h0000);
        chk(16'(o_flags), 16'h0006);
        chk(16'(o_acc), 16'h00B6);
        chk(16'(o_dir7), 16'h00B6);
        $display("back to back done");
        issue(14'h0EA1, 8'h3C);
        @(posedge i_clock) i_valid <= 1'h0;
        #1 chk(16'(o_file_write), 16'hA1C3);
        chk(16'(o_flags), 16'h0006);
        chk(16'(o_acc), 16'h00B6);
        @(posedge i_clock);
        #1 chk(16'(o_file_write.we), 16'h0000);
        issue(14'h0E05, 8'h00);
        @(posedge i_clock) i_valid <= 1'h0;
        #1 chk(16'(o_acc), 16'h0094);
        $display("swap cases done");
        @(posedge i_clock) i_rstn <= 1'h0;
        #1 chk(16'(o_acc), 16'h0000);
        chk(16'(o_dir5), 16'h00FF);
        chk(16'(o_flags), 16'h0000);
        chk(16'(o_done), 16'h0000);
        @(posedge i_clock) i_rstn <= 1'h1;
        issue(14'h0230, 8'h07);
        @(posedge i_clock) i_valid <= 1'h0;
        #1 chk(16'(o_acc), 16'h0007);
        chk(16'(o_flags), 16'h0006);
        chk(16'(o_done), 16'h0001);
        $display("mid-run reset done");
        give_verdict();
    end
endmodule
